// ===== design/hap_seq_pkg.sv
package hap_seq_pkg;

  localparam int DATA_W = 32;
  localparam int IDX_W = 8;
  localparam int NUM_SLOTS = 8;
  localparam int CYC_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h01;
  localparam logic [7:0] IDX_STATUS = 8'h02;
  localparam logic [7:0] IDX_SLOT_ID0 = 8'h08;
  localparam logic [7:0] IDX_SLOT_REPEAT = 8'h12;
  localparam logic [7:0] IDX_MAIN_LOOP = 8'h19;
  localparam logic [7:0] IDX_OD_OFFSET = 8'h1A;
  localparam logic [7:0] IDX_SP_OFFSET = 8'h1B;

  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_CLOSED_BIT = 1;
  localparam int CTRL_SHORT_BIT = 2;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_SLOT_LSB = 4;
  localparam int STATUS_PASS_LSB = 8;
  localparam int MAIN_LOOP_MSB = 2;

  localparam logic [7:0] MAIN_LOOP_RESET = 8'h00;
  localparam logic [7:0] OFFSET_RESET = 8'h00;
  localparam logic [15:0] SLOT_REPEAT_RESET = 16'h0000;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [2:0] LOOP_INFINITE = 3'h7;
  localparam logic [6:0] ID_END = 7'h00;
  localparam logic [2:0] LAST_SLOT = 3'h7;

  // Playback step times and their cycle counts at the core clock
  localparam int CLK_FREQ_KHZ = 250000;
  localparam int STEP_LONG_MS = 5;
  localparam int STEP_SHORT_MS = 1;
  localparam int STEP_LONG_CYCLES = STEP_LONG_MS * CLK_FREQ_KHZ;
  localparam int STEP_SHORT_CYCLES = STEP_SHORT_MS * CLK_FREQ_KHZ;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LAUNCH = 4'b0010,
    ST_FETCH = 4'b0100,
    ST_RUN = 4'b1000
  } state_t;

  // Signed offset applied to a step count, negative results clamp to zero
  function automatic logic [8:0] adjust_steps(input logic [7:0] steps,
                                              input logic [7:0] offset);
    logic signed [9:0] sum;
    sum = signed'({2'b00, steps}) + signed'({{2{offset[7]}}, offset});
    if (sum[9]) begin
      return 9'h000;
    end
    return sum[8:0];
  endfunction

endpackage

// ===== design/haptic_sequence_loop.sv
// Function
// - Main loop 0 plays the sequence once; 1 to 6 repeat it that often more.
// - Main loop 7 repeats forever until trigger or cleared go bit stops it.
// - Slots play in order; a pass ends at identifier 0 or after eight slots.
// - Waveform segments at the waveform's peak are overdrive and get its offset.
// - Overdrive offset only in open loop; closed loop ignores it.
// - Overdrive offset is signed; change equals offset times step time.
// - Other positive segments are positive sustain and get its offset.
// - Sustain offset is signed; change equals offset times step time.
// - Each slot's 2-bit repeat field plays its effect one to four times.
`timescale 1ns/1ps
`default_nettype none
module haptic_sequence_loop
  import hap_seq_pkg::*;
#(
  parameter int LONG_CYCLES = STEP_LONG_CYCLES,
  parameter int SHORT_CYCLES = STEP_SHORT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [DATA_W-1:0] dat_i,
  output logic [DATA_W-1:0] dat_o,
  output logic ack_o,
  // External trigger pulse
  input wire logic trig_i,
  // Waveform library
  output logic effect_start_o,
  output logic [6:0] effect_id_o,
  output logic seg_ready_o,
  input wire logic seg_valid_i,
  input wire logic [7:0] seg_amp_i,
  input wire logic [7:0] seg_steps_i,
  input wire logic seg_last_i,
  input wire logic [7:0] wave_peak_i,
  // Drive output
  output logic [7:0] drive_amp_o,
  output logic drive_active_o
);

  logic [7:0] main_loop_count;
  logic [7:0] overdrive_offset;
  logic [7:0] positive_sustain_offset;
  logic [15:0] slot_repeat_count;
  logic [6:0] slot_id [NUM_SLOTS];
  logic go;
  logic closed_loop;
  logic step_short;

  state_t st;
  logic [2:0] slot;
  logic [1:0] rep;
  logic [2:0] pass;
  logic [7:0] cur_amp;
  logic cur_last;
  logic timer_start;
  logic [8:0] timer_steps;
  logic timer_done;
  logic stop;
  logic done_evt;
  logic [CYC_W-1:0] step_cycles;

  logic bus_req;
  logic wr;
  logic [7:0] idx;
  logic [DATA_W-1:0] next_rdata;

  logic seg_od;
  logic [7:0] seg_offset;
  logic [1:0] slot_reps;
  logic pass_end;
  logic more_passes;
  logic seg_run;
  logic drive_on;

  assign bus_req = cyc_i && stb_i && !ack_o;
  assign wr = bus_req && we_i;
  assign idx = adr_i[9:2];

  // One wait state: ack in the cycle after the request is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= bus_req;
      if (bus_req && !we_i) begin
        dat_o <= next_rdata;
      end
    end
  end

  always_comb begin
    next_rdata = '0;
    if (idx >= IDX_SLOT_ID0 && idx < IDX_SLOT_ID0 + 8'(NUM_SLOTS)) begin
      next_rdata[6:0] = slot_id[3'(idx - IDX_SLOT_ID0)];
    end else begin
      unique case (idx)
        IDX_CTRL: begin
          next_rdata[CTRL_GO_BIT] = go;
          next_rdata[CTRL_CLOSED_BIT] = closed_loop;
          next_rdata[CTRL_SHORT_BIT] = step_short;
        end
        IDX_STATUS: begin
          next_rdata[STATUS_BUSY_BIT] = (st != ST_IDLE);
          next_rdata[STATUS_SLOT_LSB +: 3] = slot;
          next_rdata[STATUS_PASS_LSB +: 3] = pass;
        end
        IDX_SLOT_REPEAT: next_rdata[15:0] = slot_repeat_count;
        IDX_MAIN_LOOP: next_rdata[7:0] = main_loop_count;
        IDX_OD_OFFSET: next_rdata[7:0] = overdrive_offset;
        IDX_SP_OFFSET: next_rdata[7:0] = positive_sustain_offset;
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_loop_count <= MAIN_LOOP_RESET;
      overdrive_offset <= OFFSET_RESET;
      positive_sustain_offset <= OFFSET_RESET;
      slot_repeat_count <= SLOT_REPEAT_RESET;
      closed_loop <= CTRL_RESET[CTRL_CLOSED_BIT];
      step_short <= CTRL_RESET[CTRL_SHORT_BIT];
    end else if (wr) begin
      if (sel_i[0]) begin
        unique case (idx)
          IDX_MAIN_LOOP: main_loop_count <= dat_i[7:0];
          IDX_OD_OFFSET: overdrive_offset <= dat_i[7:0];
          IDX_SP_OFFSET: positive_sustain_offset <= dat_i[7:0];
          IDX_SLOT_REPEAT: slot_repeat_count[7:0] <= dat_i[7:0];
          IDX_CTRL: begin
            closed_loop <= dat_i[CTRL_CLOSED_BIT];
            step_short <= dat_i[CTRL_SHORT_BIT];
          end
          default: ;
        endcase
      end
      if (sel_i[1] && idx == IDX_SLOT_REPEAT) begin
        slot_repeat_count[15:8] <= dat_i[15:8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        slot_id[i] <= ID_END;
      end
    end else if (wr && sel_i[0] && idx >= IDX_SLOT_ID0 &&
                 idx < IDX_SLOT_ID0 + 8'(NUM_SLOTS)) begin
      slot_id[3'(idx - IDX_SLOT_ID0)] <= dat_i[6:0];
    end
  end

  // Software write wins; otherwise end of play or a stop clears go
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      go <= CTRL_RESET[CTRL_GO_BIT];
    end else if (wr && sel_i[0] && idx == IDX_CTRL) begin
      go <= dat_i[CTRL_GO_BIT];
    end else if (done_evt || (trig_i && st != ST_IDLE)) begin
      go <= 1'b0;
    end else if (trig_i && st == ST_IDLE) begin
      go <= 1'b1;
    end
  end

  assign stop = (st != ST_IDLE) && (trig_i || !go);
  assign seg_ready_o = (st == ST_FETCH);
  assign step_cycles = step_short ? CYC_W'(SHORT_CYCLES) :
                       CYC_W'(LONG_CYCLES);

  // Segment class: peak value is overdrive, other positives are sustain
  assign seg_od = (seg_amp_i == wave_peak_i);
  always_comb begin
    seg_offset = 8'h00;
    if (seg_od) begin
      if (!closed_loop) begin
        seg_offset = overdrive_offset;
      end
    end else if (!seg_amp_i[7] && seg_amp_i != 8'h00) begin
      seg_offset = positive_sustain_offset;
    end
  end

  assign slot_reps = slot_repeat_count[{slot, 1'b0} +: 2];
  assign pass_end = (slot == LAST_SLOT) ||
                    (slot_id[3'(slot + 3'h1)] == ID_END);
  assign more_passes = (main_loop_count[MAIN_LOOP_MSB:0] == LOOP_INFINITE) ||
                       (pass < main_loop_count[MAIN_LOOP_MSB:0]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= ST_IDLE;
      slot <= 3'h0;
      rep <= 2'h0;
      pass <= 3'h0;
      cur_amp <= 8'h00;
      cur_last <= 1'b0;
      timer_start <= 1'b0;
      timer_steps <= 9'h000;
      effect_start_o <= 1'b0;
      effect_id_o <= 7'h00;
      done_evt <= 1'b0;
    end else begin
      timer_start <= 1'b0;
      effect_start_o <= 1'b0;
      done_evt <= 1'b0;
      if (stop) begin
        st <= ST_IDLE;
      end else begin
        unique case (st)
          ST_IDLE: begin
            if (go && !done_evt) begin
              slot <= 3'h0;
              rep <= 2'h0;
              pass <= 3'h0;
              if (slot_id[0] == ID_END) begin
                done_evt <= 1'b1;
              end else begin
                st <= ST_LAUNCH;
              end
            end
          end
          ST_LAUNCH: begin
            effect_start_o <= 1'b1;
            effect_id_o <= slot_id[slot];
            st <= ST_FETCH;
          end
          ST_FETCH: begin
            if (seg_valid_i) begin
              cur_amp <= seg_amp_i;
              cur_last <= seg_last_i;
              timer_steps <= adjust_steps(seg_steps_i, seg_offset);
              timer_start <= 1'b1;
              st <= ST_RUN;
            end
          end
          ST_RUN: begin
            if (timer_done) begin
              if (!cur_last) begin
                st <= ST_FETCH;
              end else if (rep < slot_reps) begin
                rep <= rep + 2'h1;
                st <= ST_LAUNCH;
              end else if (!pass_end) begin
                rep <= 2'h0;
                slot <= slot + 3'h1;
                st <= ST_LAUNCH;
              end else if (more_passes) begin
                rep <= 2'h0;
                slot <= 3'h0;
                pass <= pass + 3'h1;
                st <= ST_LAUNCH;
              end else begin
                done_evt <= 1'b1;
                st <= ST_IDLE;
              end
            end
          end
          default: st <= ST_IDLE;
        endcase
      end
    end
  end

  // Segment is live only while its timer runs a nonzero length
  always_ff @(posedge clk_i) begin
    if (rst_i || stop) begin
      seg_run <= 1'b0;
    end else if (timer_start) begin
      seg_run <= (timer_steps != 9'h000);
    end else if (timer_done) begin
      seg_run <= 1'b0;
    end
  end

  assign drive_on = seg_run && !timer_done && !stop;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_amp_o <= 8'h00;
      drive_active_o <= 1'b0;
    end else begin
      drive_active_o <= drive_on;
      drive_amp_o <= drive_on ? cur_amp : 8'h00;
    end
  end

  step_timer #(
    .CW(CYC_W)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(timer_start),
    .abort_i(stop),
    .steps_i(timer_steps),
    .step_cycles_i(step_cycles),
    .done_o(timer_done)
  );

endmodule
`default_nettype wire

// ===== design/step_timer.sv
`timescale 1ns/1ps
`default_nettype none
module step_timer
  import hap_seq_pkg::*;
#(
  parameter int CW = CYC_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [8:0] steps_i,
  input wire logic [CW-1:0] step_cycles_i,
  output logic done_o
);

  logic running;
  logic [8:0] steps_left;
  logic [CW-1:0] cyc;

  always_ff @(posedge clk_i) begin
    if (rst_i || abort_i) begin
      running <= 1'b0;
      done_o <= 1'b0;
      steps_left <= 9'h000;
      cyc <= '0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        steps_left <= steps_i;
        cyc <= '0;
        running <= (steps_i != 9'h000);
        done_o <= (steps_i == 9'h000);
      end else if (running) begin
        if (cyc == step_cycles_i - CW'(1)) begin
          cyc <= '0;
          steps_left <= steps_left - 9'h001;
          if (steps_left == 9'h001) begin
            running <= 1'b0;
            done_o <= 1'b1;
          end
        end else begin
          cyc <= cyc + CW'(1);
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== sim/hap_seq_props.sv
`timescale 1ns/1ps
`default_nettype none
module hap_seq_props
  import hap_seq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic trig_i,
  input wire logic effect_start_o,
  input wire logic [6:0] effect_id_o,
  input wire logic [7:0] drive_amp_o,
  input wire logic drive_active_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing");
  AST_ACK_ONE: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  AST_AMP_IDLE: assert property (!drive_active_o |-> drive_amp_o == 8'h00)
    else $error("amplitude while idle");
  AST_START_ONE: assert property (effect_start_o |=> !effect_start_o)
    else $error("start pulse too long");
  AST_ID_LIVE: assert property (effect_start_o |-> effect_id_o != ID_END)
    else $error("end identifier played");
  AST_ID_HOLD: assert property ($changed(effect_id_o) |-> effect_start_o)
    else $error("identifier changed without start");
  AST_TRIG_STOP: assert property (drive_active_o && trig_i |-> ##2 !drive_active_o)
    else $error("trigger did not stop playback");
endmodule
bind haptic_sequence_loop hap_seq_props u_props (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .trig_i(trig_i),
  .effect_start_o(effect_start_o), .effect_id_o(effect_id_o),
  .drive_amp_o(drive_amp_o), .drive_active_o(drive_active_o));
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import hap_seq_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic trig = 0;
  logic sv = 0;
  logic [9:0] adr = '0;
  logic [31:0] dat = '0;
  logic [31:0] q;
  logic [7:0] amp = 8'h32;
  logic [3:0] sel = 4'hF;
  logic [3:0] lanes = 4'hF;
  logic split = 0;
  logic half = 0;
  logic [31:0] dat_o;
  logic ack_o;
  logic es;
  logic sr;
  logic da;
  logic [6:0] eid;
  logic [7:0] damp;
  int n_errors = 0;
  int n_tests = 0;
  int ns = 0;
  int nd = 0;
  int na = 0;
  int sid = 0;
  int s0;
  int k;
  haptic_sequence_loop #(.LONG_CYCLES(4), .SHORT_CYCLES(2)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .trig_i(trig), .effect_start_o(es), .effect_id_o(eid),
    .seg_ready_o(sr), .seg_valid_i(sv), .seg_amp_i(amp),
    .seg_steps_i(8'h03), .seg_last_i(!split || half), .wave_peak_i(8'h64),
    .drive_amp_o(damp), .drive_active_o(da));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // Library side: offers one segment each time the block waits
  always @(posedge clk_i) begin
    sv <= !rst_i && (sv ? !sr : sr);
    if (sv && sr) half <= split && !half;
    if (es === 1'b1) begin
      ns++;
      sid += eid;
    end
    if (da === 1'b1) nd++;
    if (da === 1'b1 && damp === amp) na++;
  end
  task automatic end_sim();
    $display("counts errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    sel <= lanes;
    adr <= {i, 2'b00};
    dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      end_sim();
    end
    q = dat_o;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task automatic play(input logic [31:0] c, input int xs, input int xd,
                      input int xi);
    int a;
    int b;
    int g;
    int h;
    int n;
    a = ns;
    b = nd;
    g = na;
    h = sid;
    bus(1, IDX_CTRL, c);
    n = 0;
    do begin
      bus(0, IDX_CTRL, 0);
      n++;
    end while (q[CTRL_GO_BIT] !== 1'b0 && n < 500);
    if (n >= 500) begin
      n_errors++;
      end_sim();
    end
    chk(32'(ns - a), 32'(xs));
    chk(32'(nd - b), 32'(xd));
    chk(32'(na - g), 32'(xd));
    chk(32'(sid - h), 32'(xi));
  endtask
  task automatic off(input logic [31:0] c, input logic [7:0] a,
                     input logic [7:0] od, input logic [7:0] sp, input int xd);
    bus(1, IDX_OD_OFFSET, {24'h0, od});
    bus(1, IDX_SP_OFFSET, {24'h0, sp});
    amp <= a;
    play(c, 1, xd, 1);
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    for (int i = 0; i < 3; i++) begin
      bus(0, IDX_MAIN_LOOP + 8'(i), 0);
      chk(q, 32'h0000_0000);
      bus(1, IDX_MAIN_LOOP + 8'(i), 32'h0000_00A5);
      bus(0, IDX_MAIN_LOOP + 8'(i), 0);
      chk(q, 32'h0000_00A5);
      bus(1, IDX_MAIN_LOOP + 8'(i), 0);
    end
    bus(1, 8'h30, 32'h0000_005A);
    bus(0, 8'h30, 0);
    chk(q, 32'h0000_0000);
    lanes = 4'h2;
    bus(1, IDX_MAIN_LOOP, 32'h0000_0033);
    bus(1, IDX_SLOT_REPEAT, 32'h0000_ABCD);
    lanes = 4'hF;
    bus(0, IDX_MAIN_LOOP, 0);
    chk(q, 32'h0000_0000);
    bus(0, IDX_SLOT_REPEAT, 0);
    chk(q, 32'h0000_AB00);
    $display("done: registers");
    bus(1, IDX_SLOT_ID0, 32'h0000_0005);
    bus(1, IDX_SLOT_REPEAT, 32'h0000_0001);
    bus(1, IDX_MAIN_LOOP, 32'h0000_0002);
    play(1, 6, 72, 30); // Three passes of a doubled slot
    for (int i = 0; i < 8; i++) bus(1, IDX_SLOT_ID0 + 8'(i), 32'(i + 1));
    bus(1, IDX_SLOT_REPEAT, 0);
    bus(1, IDX_MAIN_LOOP, 0);
    play(1, 8, 96, 36); // Full eight slots
    bus(1, IDX_SLOT_ID0 + 8'h01, 0);
    $display("done: sequencing");
    off(1, 8'h64, 8'h02, 8'h00, 20); // Peak longer
    off(5, 8'h64, 8'h02, 8'h00, 10); // Short step time
    off(3, 8'h64, 8'h02, 8'h00, 12); // Closed loop
    off(1, 8'h64, 8'hFB, 8'h00, 0); // Clamped
    off(1, 8'h32, 8'hFB, 8'hFE, 4); // Sustain shorter
    off(1, 8'hCE, 8'h00, 8'h02, 12); // Negative untouched
    split <= 1;
    off(1, 8'h32, 8'h00, 8'h00, 24); // Two segments in one effect
    split <= 0;
    $display("done: offsets");
    bus(1, IDX_MAIN_LOOP, 32'h0000_0007);
    for (int m = 0; m < 2; m++) begin
      s0 = ns;
      if (m == 0) begin
        trig <= 1;
        @(posedge clk_i);
        trig <= 0;
      end else bus(1, IDX_CTRL, 1);
      k = 0;
      while (!(ns - s0 >= 10 && da === 1'b1) && k < 1000) begin
        @(posedge clk_i);
        k++;
      end
      if (k >= 1000) begin
        n_errors++;
        end_sim();
      end
      bus(0, IDX_STATUS, 0);
      chk({31'h0, q[STATUS_BUSY_BIT]}, 32'h0000_0001);
      if (m == 0) begin
        trig <= 1;
        @(posedge clk_i);
        trig <= 0;
      end else bus(1, IDX_CTRL, 0);
      repeat (3) @(posedge clk_i);
      chk({31'h0, da}, 32'h0000_0000); // Stopped at once
      s0 = ns;
      repeat (40) @(posedge clk_i);
      chk(32'(ns - s0), 32'h0000_0000); // No effect after stop
      bus(0, IDX_STATUS, 0);
      chk({31'h0, q[STATUS_BUSY_BIT]}, 32'h0000_0000);
    end
    $display("done: endless loop");
    end_sim();
  end
endmodule
`default_nettype wire
